// ---- shared/deframer_control_defines.vh ----
// Contract
// - Character substitution bit at 1 stops end-of-frame character replacement; resets 0.
// - Soft reset bit at 1 synchronously returns deframer logic to power-on state.
// - While soft reset is 1, no received lane data is accepted.
// - Force resync bit at 1 asserts the resync request output; resets 0.
// - Errored frame substitution bit enables replacing bad frames; resets 1.
// - Qualify bit at 1 lets a not-in-table error mask a disparity error.
// - Alternative descrambler bit moves descrambling start from octet 0 to 2.
// - Policy 0: after sync, request resync only after enough disparity errors.
// - Policy 1: after sync, K followed by neither R nor K requests resync.
// - Skip alignment bit: user data follows code group sync directly; resets 0.
// - Checksum bit selects field sum (0) or packed byte sum (1).
// - Test mode bit at 1 expects sync pattern then endless alignment sequence.
// - Pattern check bit enables test pattern checking only with test mode 0.
// - Queued error bit at 1 signals every lane error in turn on request.
// - Receiver off bit at 1 disables the receiver; changed only in soft reset.
`ifndef DEFRAMER_CONTROL_DEFINES_VH
`define DEFRAMER_CONTROL_DEFINES_VH

`define ADDR_W 12
`define OFS_CONTROL_ZERO 12'h475
`define OFS_CONTROL_ONE 12'h476
`define OFS_CONTROL_TWO 12'h477

`define RST_CONTROL_ZERO 8'h01
`define RST_CONTROL_ONE 8'h14
`define RST_CONTROL_TWO 8'h00
`define MASK_CONTROL_ZERO 8'hcd
`define MASK_CONTROL_ONE 8'h1f
`define MASK_CONTROL_TWO 8'hb0

`define BIT_RECEIVER_OFF 7
`define BIT_CHAR_SUBST_OFF 6
`define BIT_SOFT_RESET 3
`define BIT_FORCE_RESYNC 2
`define BIT_FRAME_SUBST_ON 0

`define BIT_QUALIFY 4
`define BIT_ALT_DESCR 3
`define BIT_CGS_POLICY 2
`define BIT_SKIP_ALIGN 1
`define BIT_CHECKSUM 0

`define BIT_TEST_MODE 7
`define BIT_PATTERN_CHECK 5
`define BIT_QUEUED_ERR 4

`define DESCR_OCTET_DEFAULT 2'h0
`define DESCR_OCTET_ALT 2'h2

`define DISP_CNT_W 4
`define PEND_W 8
`define PEND_MAX 8'hff
`define HOLD_W 4
`define REPORT_CYCLES_DEFAULT 4
`define DISP_LIMIT_DEFAULT 4

`endif

// ---- hdl/lane_error_monitor.v ----
`timescale 1ns/10ps
`include "deframer_control_defines.vh"
module lane_error_monitor #(
    parameter DISP_LIMIT = `DISP_LIMIT_DEFAULT
) (
    input wire clk, // Device clock.
    input wire rst_n, // Synchronised reset, active low.
    input wire clear, // Soft reset, clears all state.
    input wire valid, // Character valid and accepted.
    input wire is_k, // Character is a K control character.
    input wire is_r, // Character is an R control character.
    input wire disp_err, // Running disparity error on this character.
    input wire nit_err, // Not-in-table error on this character.
    input wire cgs_done, // Code group sync achieved on this lane.
    input wire cgs_policy, // Resync policy select.
    input wire qualify_disp, // Not-in-table masks disparity when 1.
    output reg err_event, // One-cycle resync-worthy error.
    output reg disp_seen // Qualified disparity error, one cycle.
);

localparam integer DISP_LAST_INT = DISP_LIMIT - 1;
localparam [`DISP_CNT_W-1:0] DISP_LAST = DISP_LAST_INT[`DISP_CNT_W-1:0];
localparam [`DISP_CNT_W-1:0] CNT_ONE = 1;
localparam [`DISP_CNT_W-1:0] CNT_ZERO = 0;

reg [`DISP_CNT_W-1:0] disp_cnt;
reg prev_k;
wire disp_q;

assign disp_q = valid & disp_err & ~(qualify_disp & nit_err);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        disp_cnt <= CNT_ZERO;
        prev_k <= 1'b0;
        err_event <= 1'b0;
        disp_seen <= 1'b0;
    end else if (clear) begin
        disp_cnt <= CNT_ZERO;
        prev_k <= 1'b0;
        err_event <= 1'b0;
        disp_seen <= 1'b0;
    end else begin
        err_event <= 1'b0;
        disp_seen <= disp_q;
        if (valid) begin
            prev_k <= is_k;
        end
        if (!cgs_done) begin
            disp_cnt <= CNT_ZERO;
        end else if (valid) begin
            if (cgs_policy) begin
                if (prev_k && !is_k && !is_r) begin
                    err_event <= 1'b1;
                end
            end else if (disp_q) begin
                // The count restarts after each report so a steady error rate keeps reporting.
                if (disp_cnt == DISP_LAST) begin
                    err_event <= 1'b1;
                    disp_cnt <= CNT_ZERO;
                end else begin
                    disp_cnt <= disp_cnt + CNT_ONE;
                end
            end
        end
    end
end

endmodule

// ---- hdl/deframer_control.v ----
`timescale 1ns/10ps
`include "deframer_control_defines.vh"
module deframer_control #(
    parameter LANES = 8,
    parameter DISP_LIMIT = `DISP_LIMIT_DEFAULT,
    parameter REPORT_CYCLES = `REPORT_CYCLES_DEFAULT
) (
    input wire CLOCK, // Device clock, 10 MHz.
    input wire ARST_N, // Asynchronous reset, active low.
    input wire [`ADDR_W-1:0] CFG_ADDR, // Configuration port register address.
    input wire [7:0] CFG_WDATA, // Configuration port write data.
    input wire CFG_WRITE, // Write strobe, one cycle.
    input wire CFG_READ, // Read strobe, one cycle.
    output reg [7:0] CFG_RDATA, // Read data, valid the cycle after the strobe.
    input wire [LANES-1:0] LANE_VALID, // Character valid per lane.
    input wire [LANES-1:0] LANE_IS_K, // K character per lane.
    input wire [LANES-1:0] LANE_IS_R, // R character per lane.
    input wire [LANES-1:0] LANE_DISP_ERR, // Disparity error per lane.
    input wire [LANES-1:0] LANE_NIT_ERR, // Not-in-table error per lane.
    input wire [LANES-1:0] LANE_FRAME_ERR, // Frame received in error per lane.
    input wire [LANES-1:0] LANE_CGS_DONE, // Code group sync achieved per lane.
    output reg RESYNC_REQUEST_OUT, // Sync request toward transmitter, high = request.
    output reg DEFRAMER_HELD, // Deframer held in soft reset.
    output reg [LANES-1:0] LANE_ACCEPT, // Lane data accepted by the deframer.
    output reg RECEIVER_OFF, // Receiver disabled.
    output reg CHAR_SUBST_ON, // End-of-frame character replacement active.
    output reg [LANES-1:0] FRAME_SUBST, // Replace the current frame per lane.
    output reg [LANES-1:0] DISP_ERR_REPORT, // Qualified disparity error per lane.
    output reg [1:0] DESCR_START_OCTET, // Octet where descrambling starts.
    output reg SKIP_ALIGNMENT, // Expect user data right after sync.
    output reg CHECKSUM_BY_BYTES, // Checksum summed over packed bytes.
    output reg LINK_TEST_MODE, // Sync pattern then endless alignment sequence.
    output reg PATTERN_CHECK_ON, // Transport test pattern checking enabled.
    output reg QUEUED_ERRORS // Errors queued and signalled one by one.
);

////////////////////////////////////////////////////////////////////////////////

// The reset is released through two flops so that its removal never lands
// close to a clock edge in any register of the block other than those two flops.
reg rst_meta;
reg rst_n;

always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        rst_meta <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n <= rst_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////

reg [7:0] control_zero;
reg [7:0] control_one;
reg [7:0] control_two;
reg [7:0] next_control_zero;
reg [7:0] next_control_one;
reg [7:0] next_control_two;
wire [2:0] addr_sel;
wire soft_reset;

assign soft_reset = control_zero[`BIT_SOFT_RESET];

// One-hot register select; the write and the read path both decode through it,
// so the two can never disagree on which addresses are mapped.
function [2:0] reg_select;
    input [`ADDR_W-1:0] addr;
    begin
        case (addr)
            `OFS_CONTROL_ZERO: reg_select = 3'b001;
            `OFS_CONTROL_ONE: reg_select = 3'b010;
            `OFS_CONTROL_TWO: reg_select = 3'b100;
            default: reg_select = 3'b000;
        endcase
    end
endfunction

function [7:0] reg_read;
    input [2:0] sel;
    input [7:0] r0;
    input [7:0] r1;
    input [7:0] r2;
    begin
        case (sel)
            3'b001: reg_read = r0 & `MASK_CONTROL_ZERO;
            3'b010: reg_read = r1 & `MASK_CONTROL_ONE;
            3'b100: reg_read = r2 & `MASK_CONTROL_TWO;
            default: reg_read = 8'h00;
        endcase
    end
endfunction

assign addr_sel = reg_select(CFG_ADDR);

// Reserved bits are masked on the way in, so they read back as zero whatever
// software writes to them.
always @* begin
    next_control_zero = control_zero;
    next_control_one = control_one;
    next_control_two = control_two;
    if (CFG_WRITE && addr_sel[0]) begin
        next_control_zero = CFG_WDATA & `MASK_CONTROL_ZERO;
    end
    if (CFG_WRITE && addr_sel[1]) begin
        next_control_one = CFG_WDATA & `MASK_CONTROL_ONE;
    end
    if (CFG_WRITE && addr_sel[2]) begin
        next_control_two = CFG_WDATA & `MASK_CONTROL_TWO;
    end
end

// Writes are stored whenever they arrive; the active copies below only take
// them at soft reset; during operation only the soft reset and force resync bits act at once.
always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
        control_zero <= `RST_CONTROL_ZERO;
        control_one <= `RST_CONTROL_ONE;
        control_two <= `RST_CONTROL_TWO;
        CFG_RDATA <= 8'h00;
    end else begin
        control_zero <= next_control_zero;
        control_one <= next_control_one;
        control_two <= next_control_two;
        if (CFG_READ) begin
            // A read in the same cycle as a write returns the older value.
            CFG_RDATA <= reg_read(addr_sel, control_zero, control_one, control_two);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

reg cfg_qualify;
reg cfg_policy;
reg cfg_frame_subst;

// Active copies track the registers while held, so the value standing at the
// release is the one used for the whole run.
always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
        cfg_qualify <= 1'b1;
        cfg_policy <= 1'b1;
        cfg_frame_subst <= 1'b1;
        RECEIVER_OFF <= 1'b0;
        CHAR_SUBST_ON <= 1'b1;
        DESCR_START_OCTET <= `DESCR_OCTET_DEFAULT;
        SKIP_ALIGNMENT <= 1'b0;
        CHECKSUM_BY_BYTES <= 1'b0;
        LINK_TEST_MODE <= 1'b0;
        PATTERN_CHECK_ON <= 1'b0;
        QUEUED_ERRORS <= 1'b0;
    end else if (soft_reset) begin
        cfg_qualify <= control_one[`BIT_QUALIFY];
        cfg_policy <= control_one[`BIT_CGS_POLICY];
        cfg_frame_subst <= control_zero[`BIT_FRAME_SUBST_ON];
        RECEIVER_OFF <= control_zero[`BIT_RECEIVER_OFF];
        CHAR_SUBST_ON <= ~control_zero[`BIT_CHAR_SUBST_OFF];
        DESCR_START_OCTET <= control_one[`BIT_ALT_DESCR] ?
            `DESCR_OCTET_ALT : `DESCR_OCTET_DEFAULT;
        SKIP_ALIGNMENT <= control_one[`BIT_SKIP_ALIGN];
        CHECKSUM_BY_BYTES <= control_one[`BIT_CHECKSUM];
        LINK_TEST_MODE <= control_two[`BIT_TEST_MODE];
        // The pattern check is refused while the link layer test mode is chosen.
        PATTERN_CHECK_ON <= control_two[`BIT_PATTERN_CHECK] &
            ~control_two[`BIT_TEST_MODE];
        QUEUED_ERRORS <= control_two[`BIT_QUEUED_ERR];
    end
end

////////////////////////////////////////////////////////////////////////////////

wire [LANES-1:0] accept;
wire [LANES-1:0] subst_now;
wire [LANES-1:0] lane_err;
wire [LANES-1:0] lane_disp;

genvar g;
generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
        // A disabled or held receiver drops lane data before the monitors see it.
        assign accept[g] = LANE_VALID[g] & ~(soft_reset | RECEIVER_OFF);
        assign subst_now[g] = cfg_frame_subst & LANE_FRAME_ERR[g] & accept[g];
        lane_error_monitor #(
            .DISP_LIMIT(DISP_LIMIT)
        ) u_monitor (
            .clk(CLOCK),
            .rst_n(rst_n),
            .clear(soft_reset),
            .valid(accept[g]),
            .is_k(LANE_IS_K[g]),
            .is_r(LANE_IS_R[g]),
            .disp_err(LANE_DISP_ERR[g]),
            .nit_err(LANE_NIT_ERR[g]),
            .cgs_done(LANE_CGS_DONE[g]),
            .cgs_policy(cfg_policy),
            .qualify_disp(cfg_qualify),
            .err_event(lane_err[g]),
            .disp_seen(lane_disp[g])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

// The queue saturates rather than wraps; reports are lost only once 255 are
// outstanding, which takes a link that has been failing for a long time.
function [`PEND_W-1:0] count_ones;
    input [LANES-1:0] bits;
    integer i;
    begin
        count_ones = {`PEND_W{1'b0}};
        for (i = 0; i < LANES; i = i + 1) begin
            count_ones = count_ones + {{(`PEND_W-1){1'b0}}, bits[i]};
        end
    end
endfunction

localparam integer HOLD_LOAD_INT = REPORT_CYCLES;
localparam [`HOLD_W-1:0] HOLD_LOAD = HOLD_LOAD_INT[`HOLD_W-1:0];
localparam [`HOLD_W-1:0] HOLD_ONE = 1;
localparam [`HOLD_W-1:0] HOLD_ZERO = 0;
localparam [`PEND_W:0] PEND_ONE = 1;

reg [`PEND_W-1:0] pending;
reg [`HOLD_W-1:0] hold;
reg [`PEND_W-1:0] add;
reg take;
reg [`PEND_W:0] sum;
reg [`PEND_W-1:0] next_pending;
reg [`HOLD_W-1:0] next_hold;
reg next_resync;

always @* begin
    if (QUEUED_ERRORS) begin
        add = count_ones(lane_err);
    end else begin
        add = {{(`PEND_W-1){1'b0}}, |lane_err};
    end
    take = (hold == HOLD_ZERO) && (pending != {`PEND_W{1'b0}});
    // New errors are added before the served one is taken, so an error in the
    // same cycle as a take is never lost.
    sum = {1'b0, pending} + {1'b0, add} - (take ? PEND_ONE : {(`PEND_W+1){1'b0}});
    next_pending = sum[`PEND_W] ? `PEND_MAX : sum[`PEND_W-1:0];
end

// Each report holds the request for a fixed window and the next one starts
// one cycle after it ends, so a long queue drains at a steady, predictable rate.
always @* begin
    if (take) begin
        next_hold = HOLD_LOAD;
    end else if (hold != HOLD_ZERO) begin
        next_hold = hold - HOLD_ONE;
    end else begin
        next_hold = HOLD_ZERO;
    end
    // Request until every lane has code group sync, on command, or while an
    // error report window is open.
    next_resync = control_zero[`BIT_FORCE_RESYNC] | ~(&LANE_CGS_DONE) |
        (next_hold != HOLD_ZERO);
end

always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
        pending <= {`PEND_W{1'b0}};
        hold <= HOLD_ZERO;
        RESYNC_REQUEST_OUT <= 1'b1;
        DEFRAMER_HELD <= 1'b0;
    end else if (soft_reset) begin
        pending <= {`PEND_W{1'b0}};
        hold <= HOLD_ZERO;
        RESYNC_REQUEST_OUT <= 1'b1;
        DEFRAMER_HELD <= 1'b1;
    end else begin
        pending <= next_pending;
        hold <= next_hold;
        RESYNC_REQUEST_OUT <= next_resync;
        DEFRAMER_HELD <= 1'b0;
    end
end

// Lane outputs trail their inputs by one cycle (DISP_ERR_REPORT by two), so downstream logic sees them
// aligned with the registered character rather than the raw one.
always @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
        LANE_ACCEPT <= {LANES{1'b0}};
        FRAME_SUBST <= {LANES{1'b0}};
        DISP_ERR_REPORT <= {LANES{1'b0}};
    end else if (soft_reset) begin
        LANE_ACCEPT <= {LANES{1'b0}};
        FRAME_SUBST <= {LANES{1'b0}};
        DISP_ERR_REPORT <= {LANES{1'b0}};
    end else begin
        LANE_ACCEPT <= accept;
        FRAME_SUBST <= subst_now;
        DISP_ERR_REPORT <= lane_disp;
    end
end

endmodule

// ---- dv/deframer_control_asserts.sv ----
`timescale 1ns/10ps
`include "deframer_control_defines.vh"
module deframer_control_asserts #(
    parameter LANES = 8
) (
    input wire CLOCK, // Device clock.
    input wire ARST_N, // Reset, active low.
    input wire [`ADDR_W-1:0] CFG_ADDR, // Address.
    input wire [7:0] CFG_WDATA, // Write data.
    input wire CFG_WRITE, // Write strobe.
    input wire RESYNC_REQUEST_OUT, // Sync request.
    input wire DEFRAMER_HELD, // In soft reset.
    input wire [LANES-1:0] LANE_ACCEPT, // Accepted data.
    input wire [1:0] DESCR_START_OCTET, // Descrambler start.
    input wire SKIP_ALIGNMENT, // Copy.
    input wire CHECKSUM_BY_BYTES, // Copy.
    input wire LINK_TEST_MODE, // Copy.
    input wire PATTERN_CHECK_ON, // Copy.
    input wire QUEUED_ERRORS // Copy.
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);
    wire ctl0_wr = CFG_WRITE && CFG_ADDR == `OFS_CONTROL_ZERO;
    wire [3:0] cfg = {SKIP_ALIGNMENT, CHECKSUM_BY_BYTES, LINK_TEST_MODE, QUEUED_ERRORS};
    ////////////////////////////////////////////////////////////////////////////
    property p_held; ctl0_wr && CFG_WDATA[3] |-> ##2 DEFRAMER_HELD; endproperty
    a_held: assert property (p_held) else $error("soft reset not applied");
    property p_held_req; DEFRAMER_HELD |-> RESYNC_REQUEST_OUT; endproperty
    a_held_req: assert property (p_held_req) else $error("request low while held");
    property p_no_accept; DEFRAMER_HELD |-> LANE_ACCEPT == '0; endproperty
    a_no_accept: assert property (p_no_accept) else $error("data taken while held");
    property p_force; ctl0_wr && CFG_WDATA[2] |-> ##[1:3] RESYNC_REQUEST_OUT; endproperty
    a_force: assert property (p_force) else $error("forced request missing");
    property p_octet; DESCR_START_OCTET == 2'h0 || DESCR_START_OCTET == 2'h2; endproperty
    a_octet: assert property (p_octet) else $error("bad descrambler start");
    property p_pattern; LINK_TEST_MODE |-> !PATTERN_CHECK_ON; endproperty
    a_pattern: assert property (p_pattern) else $error("pattern check in test mode");
    property p_stable; !DEFRAMER_HELD [*3] |-> $stable(cfg); endproperty
    a_stable: assert property (p_stable) else $error("config moved while running");
    property p_window; $rose(RESYNC_REQUEST_OUT) && !DEFRAMER_HELD |-> RESYNC_REQUEST_OUT [*4];
    endproperty
    a_window: assert property (p_window) else $error("report window too short");
endmodule

bind deframer_control deframer_control_asserts #(.LANES(LANES)) u_asserts (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
    .CFG_WRITE(CFG_WRITE), .RESYNC_REQUEST_OUT(RESYNC_REQUEST_OUT),
    .DEFRAMER_HELD(DEFRAMER_HELD), .LANE_ACCEPT(LANE_ACCEPT),
    .DESCR_START_OCTET(DESCR_START_OCTET), .SKIP_ALIGNMENT(SKIP_ALIGNMENT),
    .CHECKSUM_BY_BYTES(CHECKSUM_BY_BYTES), .LINK_TEST_MODE(LINK_TEST_MODE),
    .PATTERN_CHECK_ON(PATTERN_CHECK_ON), .QUEUED_ERRORS(QUEUED_ERRORS));

// ---- dv/lane_framer_model.sv ----
`timescale 1ns/10ps
module lane_framer_model #(
    parameter LANES = 8
) (
    input wire clk, // Device clock.
    input wire [1:0] kind, // 0 idle, 1 K, 2 R, 3 data.
    input wire disp_bad, // Disparity error.
    input wire nit_bad, // Not-in-table error.
    input wire frame_bad, // Frame in error.
    output wire [LANES-1:0] valid, // Valid.
    output wire [LANES-1:0] is_k, // K character.
    output wire [LANES-1:0] is_r, // R character.
    output wire [LANES-1:0] disp_err, // Disparity error.
    output wire [LANES-1:0] nit_err, // Not in table.
    output wire [LANES-1:0] frame_err, // Frame error.
    output wire [LANES-1:0] cgs_done // Sync reached.
);
    reg flip = 1'b0;
    wire on = kind != 2'h0;
    // Idle lanes wiggle their qualifiers so no stale character can pass for a real one.
    always @(posedge clk) begin
        flip <= ~flip;
    end
    assign valid = {LANES{on}};
    assign is_k = {LANES{on ? kind == 2'h1 : flip}};
    assign is_r = {LANES{on ? kind == 2'h2 : ~flip}};
    assign disp_err = {LANES{on & disp_bad}};
    assign nit_err = {LANES{on & nit_bad}};
    assign frame_err = {LANES{on & frame_bad}};
    assign cgs_done = {LANES{1'b1}};
endmodule

// ---- dv/deframer_control_bench.sv ----
`timescale 1ns/10ps
`include "deframer_control_defines.vh"
module deframer_control_bench;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg [`ADDR_W-1:0] cfg_addr = 12'h000;
    reg [7:0] cfg_wdata = 8'h00;
    reg cfg_write = 1'b0;
    reg cfg_read = 1'b0;
    reg [1:0] kind = 2'h0;
    reg disp_bad = 1'b0;
    reg nit_bad = 1'b0;
    reg frame_bad = 1'b0;
    wire [7:0] cfg_rdata, valid, is_k, is_r, disp_err, nit_err, frame_err, cgs_done;
    wire [7:0] accept, fsubst, drep;
    wire [1:0] octet;
    wire resync, held, rx_off, char_on, skip, csum, test_mode, pat_on, queued;
    wire [8:0] cfg_vec = {rx_off, char_on, octet, skip, csum, test_mode, pat_on, queued};
    integer failures = 0;
    integer n_compared = 0;
    integer i;
    integer hits;
    reg [7:0] acc;

    always #50 clock = ~clock;

    lane_framer_model #(.LANES(8)) partner (.clk(clock), .kind(kind), .disp_bad(disp_bad),
        .nit_bad(nit_bad), .frame_bad(frame_bad), .valid(valid), .is_k(is_k), .is_r(is_r),
        .disp_err(disp_err), .nit_err(nit_err), .frame_err(frame_err), .cgs_done(cgs_done));

    deframer_control #(.LANES(8), .DISP_LIMIT(4), .REPORT_CYCLES(4)) uut (
        .CLOCK(clock), .ARST_N(arst_n), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
        .CFG_WRITE(cfg_write), .CFG_READ(cfg_read), .CFG_RDATA(cfg_rdata),
        .LANE_VALID(valid), .LANE_IS_K(is_k), .LANE_IS_R(is_r), .LANE_DISP_ERR(disp_err),
        .LANE_NIT_ERR(nit_err), .LANE_FRAME_ERR(frame_err), .LANE_CGS_DONE(cgs_done),
        .RESYNC_REQUEST_OUT(resync), .DEFRAMER_HELD(held), .LANE_ACCEPT(accept),
        .RECEIVER_OFF(rx_off), .CHAR_SUBST_ON(char_on), .FRAME_SUBST(fsubst),
        .DISP_ERR_REPORT(drep), .DESCR_START_OCTET(octet), .SKIP_ALIGNMENT(skip),
        .CHECKSUM_BY_BYTES(csum), .LINK_TEST_MODE(test_mode), .PATTERN_CHECK_ON(pat_on),
        .QUEUED_ERRORS(queued));

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            if (failures == 0 && n_compared > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask

    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input [11:0] a, input [7:0] d);
        begin
            @(negedge clock);
            cfg_addr = a;
            cfg_wdata = d;
            cfg_write = 1'b1;
            @(negedge clock);
            cfg_write = 1'b0;
        end
    endtask

    task rd(input [11:0] a, input [7:0] exp);
        begin
            @(negedge clock);
            cfg_addr = a;
            cfg_read = 1'b1;
            @(negedge clock);
            cfg_read = 1'b0;
            check(cfg_rdata, exp);
        end
    endtask

    task send(input [1:0] k, input d, input n, input f);
        begin
            @(negedge clock);
            kind = k;
            disp_bad = d;
            nit_bad = n;
            frame_bad = f;
        end
    endtask

    // Counts request cycles over a fixed span, so a stuck request cannot hang the run.
    task count_req(input integer cycles, input [15:0] exp);
        begin
            hits = 0;
            for (i = 0; i < cycles; i = i + 1) begin
                @(negedge clock);
                if (resync === 1'b1) hits = hits + 1;
            end
            check(hits[15:0], exp);
        end
    endtask

    task probe(input n, input [7:0] exp);
        begin
            send(2'h1, 1'b1, n, 1'b0);
            send(2'h0, 1'b0, 1'b0, 1'b0);
            acc = 8'h00;
            repeat (4) @(negedge clock) acc = acc | drep;
            check(acc, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        failures = failures + 1;
        report_and_stop;
    end

    initial begin
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        rd(12'h475, 8'h01);
        rd(12'h476, 8'h14);
        rd(12'h477, 8'h00);
        rd(12'h47c, 8'h00);
        check(resync, 1'b0);
        wr(12'h475, 8'h08);
        send(2'h3, 1'b0, 1'b0, 1'b0);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        check({held, resync, accept}, 16'h0300);
        check(cfg_vec, 16'h0080);
        wr(12'h476, 8'hff);
        rd(12'h476, 8'h1f);
        wr(12'h477, 8'hff);
        rd(12'h477, 8'hb0);
        wr(12'h475, 8'hff);
        rd(12'h475, 8'hcd);
        repeat (2) @(negedge clock);
        check(cfg_vec, 16'h015d);
        wr(12'h476, 8'h00);
        wr(12'h477, 8'h30);
        wr(12'h475, 8'h09);
        repeat (2) @(negedge clock);
        check(cfg_vec, 16'h0083);
        wr(12'h475, 8'h01);
        wr(12'h476, 8'h1f);
        repeat (3) @(negedge clock);
        check(cfg_vec, 16'h0083);
        repeat (3) send(2'h1, 1'b1, 1'b0, 1'b0);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        count_req(10, 16'd0);
        send(2'h1, 1'b1, 1'b0, 1'b0);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        count_req(50, 16'd32);
        wr(12'h475, 8'h09);
        wr(12'h476, 8'h14);
        wr(12'h477, 8'h00);
        wr(12'h475, 8'h01);
        repeat (3) @(negedge clock);
        send(2'h1, 1'b0, 1'b0, 1'b0);
        send(2'h3, 1'b0, 1'b0, 1'b0);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        count_req(12, 16'd4);
        send(2'h1, 1'b0, 1'b0, 1'b0);
        send(2'h2, 1'b0, 1'b0, 1'b0);
        send(2'h1, 1'b0, 1'b0, 1'b0);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        count_req(12, 16'd0);
        probe(1'b1, 8'h00);
        probe(1'b0, 8'hff);
        send(2'h2, 1'b0, 1'b0, 1'b0);
        send(2'h3, 1'b0, 1'b0, 1'b1);
        @(negedge clock);
        check({accept, fsubst}, 16'hffff);
        send(2'h0, 1'b0, 1'b0, 1'b0);
        wr(12'h475, 8'h05);
        repeat (3) @(negedge clock);
        check(resync, 1'b1);
        wr(12'h475, 8'h01);
        repeat (3) @(negedge clock);
        check(resync, 1'b0);
        report_and_stop;
    end
endmodule
